// ==== hdl/dew_defs.svh ====
`ifndef DEW_DEFS_SVH
`define DEW_DEFS_SVH
// register offsets (plain port, byte index)
`define DEW_OFS_CTRL      4'h0
`define DEW_OFS_KEY       4'h1
`define DEW_OFS_IDX_LO    4'h2
`define DEW_OFS_IDX_HI    4'h3
`define DEW_OFS_VALUE     4'h4
`define DEW_OFS_FLAGS     4'h5
`define DEW_OFS_ENABLES   4'h6
`define DEW_OFS_PRIORITY  4'h7
`define DEW_OFS_INTCTL    4'h8
// control register fields
`define DEW_CTL_RD        0
`define DEW_CTL_WR        1
`define DEW_CTL_GATE      2
`define DEW_CTL_ERR       3
`define DEW_CTL_FREE      4
`define DEW_CTL_CFG_SEL   6
`define DEW_CTL_MSEL      7
// peripheral flag field, interrupt control fields
`define DEW_FLG_DONE      4
`define DEW_INT_GLOBAL    7
`define DEW_INT_PEIE      6
// unlock key values
`define DEW_KEY_FIRST     8'h55
`define DEW_KEY_SECOND    8'hAA
// reset values, peripheral bit mask
`define DEW_RST_BYTE      8'h00
`define DEW_RST_PRIO      8'h5F
`define DEW_MASK_PERIPH   8'h5F
// timing
`define DEW_CLK_HZ        40000000
`define DEW_PUT_MS        72
`define DEW_PUT_CYCLES    ((`DEW_CLK_HZ / 1000) * `DEW_PUT_MS)
`define DEW_WRITE_US      4000
`define DEW_WRITE_CYCLES  ((`DEW_CLK_HZ / 1000000) * `DEW_WRITE_US)
`endif

// ==== hdl/dew_pkg.sv ====
package dew_pkg;
	typedef enum logic [3:0] {
		DEW_KEY_IDLE  = 4'h1,
		DEW_KEY_GOT55 = 4'h2,
		DEW_KEY_ARMED = 4'h4,
		DEW_KEY_BUSY  = 4'h8
	} dew_key_e;
endpackage

// ==== hdl/dew_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module dew_sync3 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// ------------------------------------------------
	// three stages, change accepted when last two agree
	// ------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q_o  <= 1'b0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q_o <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/dew_write_guard.sv ====
// Function
// - write-enable gate is zero after power-up reset; code clears it on rst_i only, not on por_i
// - no write starts while power-up delay timer runs
// - write starts only after 55h, AAh, then trigger, with writes enabled
// - both key sequence and write-enable gate needed for a write
// - code protect blocks external programming-port reads and writes
// - own CPU reads and writes regardless of code protect
// - write trigger stays set for whole write, cleared at end
// - array is byte addressed and byte accessed
// - read/write triggers set-only; hardware clears; read data next cycle
// - write end sets sticky done flag until software clears
// - reset during write sets aborted flag, keeps select bits, clears erase bit
// - busy write locks control, index, value; trigger and gate not same write
`timescale 1ns/1ps
`default_nettype none
`include "dew_defs.svh"
module dew_write_guard #(
	parameter int          ADDR_W      = 10,
	parameter int unsigned PUT_CYCLES  = `DEW_PUT_CYCLES,
	parameter int unsigned WRITE_CYCLES = `DEW_WRITE_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        code_protect_i,
	input  wire logic        ext_rd_i,
	input  wire logic        ext_wr_i,
	input  wire logic [ADDR_W-1:0] ext_addr_i,
	input  wire logic [7:0]  ext_wdata_i,
	output logic      [7:0]  ext_rdata_o,
	output logic             ext_refused_o,
	output logic             irq_o
);
	localparam int DEPTH = 1 << ADDR_W;
	logic [7:0] mem_q [DEPTH];
	logic [7:0] idx_lo_q;
	logic [1:0] idx_hi_q;
	logic [7:0] value_q;
	logic       gate_q, wr_q, err_q, free_q, cfg_sel_q, msel_q;
	logic [7:0] flags_q, enables_q, prio_q, intctl_q;
	logic [31:0] put_q;
	logic [31:0] wcnt_q;
	logic        put_busy;
	logic        cp_sync;
	dew_pkg::dew_key_e key_q;
	logic        ctl_wr, key_wr, start, wdone;
	logic [ADDR_W-1:0] idx;
	logic [7:0]  rdata_d;
	logic        busy_at_reset_q;
	assign idx = ADDR_W'({idx_hi_q, idx_lo_q});
	assign ctl_wr = wr_i && addr_i == `DEW_OFS_CTRL;
	assign key_wr = wr_i && addr_i == `DEW_OFS_KEY;
	assign put_busy = put_q != 32'h0;
	// ------------------------------------------------
	// power-up delay timer, only restarted by power-on
	// ------------------------------------------------
	always_ff @(posedge clk_i or posedge por_i) begin
		if (por_i) begin
			put_q <= PUT_CYCLES;
		end else if (put_q != 32'h0) begin
			put_q <= put_q - 32'h1;
		end
	end
	// ------------------------------------------------
	// unlock key tracking
	// ------------------------------------------------
	// trigger accepted only as armed
	assign start = key_q == dew_pkg::DEW_KEY_ARMED && ctl_wr && wdata_i[`DEW_CTL_WR]
	               && gate_q && !put_busy;
	assign wdone = wr_q && wcnt_q == 32'h1;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_q <= dew_pkg::DEW_KEY_IDLE;
		end else begin
			case (key_q)
				dew_pkg::DEW_KEY_IDLE: begin
					if (key_wr && wdata_i == `DEW_KEY_FIRST) begin
						key_q <= dew_pkg::DEW_KEY_GOT55;
					end
				end
				dew_pkg::DEW_KEY_GOT55: begin
					if (key_wr && wdata_i == `DEW_KEY_SECOND) begin
						key_q <= dew_pkg::DEW_KEY_ARMED;
					end else if (wr_i || rd_i) begin
						key_q <= dew_pkg::DEW_KEY_IDLE;
					end
				end
				dew_pkg::DEW_KEY_ARMED: begin
					if (start) begin
						key_q <= dew_pkg::DEW_KEY_BUSY;
					end else if (wr_i || rd_i) begin
						key_q <= dew_pkg::DEW_KEY_IDLE;
					end
				end
				dew_pkg::DEW_KEY_BUSY: begin
					if (wdone) begin
						key_q <= dew_pkg::DEW_KEY_IDLE;
					end
				end
				default: key_q <= dew_pkg::DEW_KEY_IDLE;
			endcase
		end
	end
	// ------------------------------------------------
	// self-timed write and array
	// ------------------------------------------------
	// trigger held until timer ends
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q   <= 1'b0;
			wcnt_q <= 32'h0;
		end else if (start) begin
			wr_q   <= 1'b1;
			wcnt_q <= WRITE_CYCLES;
		end else if (wr_q) begin
			wcnt_q <= wcnt_q - 32'h1;
			if (wdone) begin
				wr_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (wdone && !msel_q && !cfg_sel_q) begin
			mem_q[idx] <= value_q;
		end else if (ext_wr_i && !cp_sync && !wr_q) begin
			mem_q[ext_addr_i] <= ext_wdata_i;
		end
	end
	dew_sync3 u_cp_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (code_protect_i),
		.q_o   (cp_sync)
	);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_rdata_o   <= `DEW_RST_BYTE;
			ext_refused_o <= 1'b0;
		end else begin
			ext_refused_o <= (ext_rd_i || ext_wr_i) && cp_sync;
			if (ext_rd_i && !cp_sync) begin
				ext_rdata_o <= mem_q[ext_addr_i];
			end else if (ext_rd_i) begin
				ext_rdata_o <= `DEW_RST_BYTE;
			end
		end
	end
	// ------------------------------------------------
	// control, index and value registers
	// ------------------------------------------------
	// gate cleared by rst_i, not by por_i
	// locked while busy, gate not set with trigger
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_q   <= 1'b0;
			free_q   <= 1'b0;
			idx_lo_q <= `DEW_RST_BYTE;
			idx_hi_q <= 2'h0;
			value_q  <= `DEW_RST_BYTE;
		end else if (!wr_q) begin
			if (ctl_wr && !wdata_i[`DEW_CTL_WR]) begin
				gate_q <= wdata_i[`DEW_CTL_GATE];
				free_q <= wdata_i[`DEW_CTL_FREE];
			end else if (ctl_wr && !gate_q) begin
				free_q <= wdata_i[`DEW_CTL_FREE];
			end
			if (wr_i && addr_i == `DEW_OFS_IDX_LO) begin
				idx_lo_q <= wdata_i;
			end
			if (wr_i && addr_i == `DEW_OFS_IDX_HI) begin
				idx_hi_q <= wdata_i[1:0];
			end
			if (ctl_wr && wdata_i[`DEW_CTL_RD] && !msel_q) begin
				value_q <= mem_q[idx];
			end else if (wr_i && addr_i == `DEW_OFS_VALUE) begin
				value_q <= wdata_i;
			end
		end
	end
	always_ff @(posedge clk_i or posedge por_i) begin
		if (por_i) begin
			msel_q    <= 1'b0;
			cfg_sel_q <= 1'b0;
		end else if (ctl_wr && !wr_q) begin
			msel_q    <= wdata_i[`DEW_CTL_MSEL];
			cfg_sel_q <= wdata_i[`DEW_CTL_CFG_SEL];
		end
	end
	// aborted flag set by reset mid-write
	always_ff @(posedge clk_i or posedge por_i) begin
		if (por_i) begin
			busy_at_reset_q <= 1'b0;
			err_q           <= 1'b0;
		end else begin
			busy_at_reset_q <= wr_q && !rst_i;
			if (rst_i && busy_at_reset_q) begin
				err_q <= 1'b1;
			end else if (ctl_wr && !wr_q) begin
				err_q <= wdata_i[`DEW_CTL_ERR];
			end
		end
	end
	// ------------------------------------------------
	// interrupt flags, enables, priority
	// ------------------------------------------------
	// done flag sticky, set beats clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flags_q   <= `DEW_RST_BYTE;
			enables_q <= `DEW_RST_BYTE;
			prio_q    <= `DEW_RST_PRIO;
			intctl_q  <= `DEW_RST_BYTE;
		end else begin
			if (wr_i && addr_i == `DEW_OFS_FLAGS) begin
				flags_q <= flags_q & ~(wdata_i & `DEW_MASK_PERIPH);
			end
			if (wdone) begin
				flags_q[`DEW_FLG_DONE] <= 1'b1;
			end
			if (wr_i && addr_i == `DEW_OFS_ENABLES) begin
				enables_q <= wdata_i & `DEW_MASK_PERIPH;
			end
			if (wr_i && addr_i == `DEW_OFS_PRIORITY) begin
				prio_q <= wdata_i & `DEW_MASK_PERIPH;
			end
			if (wr_i && addr_i == `DEW_OFS_INTCTL) begin
				intctl_q <= wdata_i;
			end
		end
	end
	assign irq_o = |(flags_q & enables_q) && intctl_q[`DEW_INT_GLOBAL]
	               && intctl_q[`DEW_INT_PEIE];
	// ------------------------------------------------
	// read port, data one cycle after strobe
	// ------------------------------------------------
	always_comb begin
		rdata_d = `DEW_RST_BYTE;
		if (addr_i == `DEW_OFS_CTRL) begin
			rdata_d = {msel_q, cfg_sel_q, 1'b0, free_q, err_q, gate_q, wr_q, 1'b0};
		end else if (addr_i == `DEW_OFS_IDX_LO) begin
			rdata_d = idx_lo_q;
		end else if (addr_i == `DEW_OFS_IDX_HI) begin
			rdata_d = {6'h00, idx_hi_q};
		end else if (addr_i == `DEW_OFS_VALUE) begin
			rdata_d = value_q;
		end else if (addr_i == `DEW_OFS_FLAGS) begin
			rdata_d = flags_q;
		end else if (addr_i == `DEW_OFS_ENABLES) begin
			rdata_d = enables_q;
		end else if (addr_i == `DEW_OFS_PRIORITY) begin
			rdata_d = prio_q;
		end else if (addr_i == `DEW_OFS_INTCTL) begin
			rdata_d = intctl_q;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= `DEW_RST_BYTE;
		end else if (rd_i) begin
			rdata_o <= rdata_d;
		end else begin
			rdata_o <= `DEW_RST_BYTE;
		end
	end
endmodule
`default_nettype wire

// ==== dv/dew_write_guard_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dew_defs.svh"
module dew_write_guard_sva (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       por_i,
	input wire logic [3:0] addr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       code_protect_i,
	input wire logic       ext_rd_i,
	input wire logic       ext_wr_i,
	input wire logic [7:0] ext_rdata_o,
	input wire logic       ext_refused_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);
	a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside slot");
	a_key_reads_zero: assert property (rd_i && addr_i == `DEW_OFS_KEY |=> rdata_o == 8'h00)
		else $error("key register not zero");
	a_index_high_narrow: assert property (rd_i && addr_i == `DEW_OFS_IDX_HI |=> !rdata_o[7:2])
		else $error("index high upper bits set");
	a_flags_unused_zero: assert property (rd_i && addr_i == `DEW_OFS_FLAGS |=> !rdata_o[7])
		else $error("flags unused bit set");
	a_ctrl_gap_zero: assert property (rd_i && addr_i == `DEW_OFS_CTRL |=> !rdata_o[5])
		else $error("control unused bit set");
	a_unmapped_zero: assert property (rd_i && addr_i > `DEW_OFS_INTCTL |=> !rdata_o)
		else $error("unmapped offset not zero");
	a_protect_refuses: assert property (code_protect_i [*6] ##0 (ext_rd_i || ext_wr_i)
		|=> ext_refused_o && ext_rdata_o == 8'h00)
		else $error("protected access not refused");
	a_refusal_cause: assert property (ext_refused_o |-> $past(ext_rd_i || ext_wr_i))
		else $error("refusal without request");
endmodule
bind dew_write_guard dew_write_guard_sva u_sva (
	.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .addr_i(addr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .code_protect_i(code_protect_i), .ext_rd_i(ext_rd_i),
	.ext_wr_i(ext_wr_i), .ext_rdata_o(ext_rdata_o), .ext_refused_o(ext_refused_o)
);
`default_nettype wire

// ==== dv/dew_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dew_defs.svh"
module dew_cpu_model (
	input  wire logic       clk_i,
	output logic      [3:0] addr_o  = 4'h0,
	output logic      [7:0] wdata_o = 8'h00,
	output logic            wr_o    = 1'b0,
	output logic            rd_o    = 1'b0,
	input  wire logic [7:0] rdata_i
);
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
		@(posedge clk_i);
	endtask
	task automatic unlock(input logic [7:0] c);
		wr(`DEW_OFS_KEY, `DEW_KEY_FIRST);
		wr(`DEW_OFS_KEY, `DEW_KEY_SECOND);
		wr(`DEW_OFS_CTRL, c);
	endtask
endmodule
`default_nettype wire

// ==== dv/dew_write_guard_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dew_defs.svh"
module dew_write_guard_tb_top;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       por_i = 1'b1;
	logic       prot  = 1'b0;
	logic       e_rd  = 1'b0;
	logic       e_wr  = 1'b0;
	logic [9:0] e_addr = 10'h3FF;
	logic [7:0] e_wdat = 8'h5A;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [7:0] e_data;
	logic       e_ref;
	logic       irq;
	int         bad_count = 0;
	int         checks = 0;
	always #12.5 clk_i = ~clk_i;
	dew_cpu_model cpu (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata));
	dew_write_guard #(.PUT_CYCLES(20), .WRITE_CYCLES(20)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .code_protect_i(prot), .ext_rd_i(e_rd),
		.ext_wr_i(e_wr), .ext_addr_i(e_addr), .ext_wdata_i(e_wdat), .ext_rdata_o(e_data),
		.ext_refused_o(e_ref), .irq_o(irq));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
		logic [7:0] v;
		cpu.rd(a, v);
		chk(n, e, v);
	endtask
	task automatic ext(input logic w, input logic [7:0] e, input logic r);
		e_rd <= !w;
		e_wr <= w;
		@(posedge clk_i);
		e_rd <= 1'b0;
		e_wr <= 1'b0;
		#1 chk("ext refused", {7'h00, r}, {7'h00, e_ref});
		chk("ext data", e, e_data);
		@(posedge clk_i);
	endtask
	task automatic t_power_up;
		rc(`DEW_OFS_CTRL, 8'h00, "gate at reset");
		cpu.wr(`DEW_OFS_CTRL, 8'h04);
		cpu.unlock(8'h06);
		rc(`DEW_OFS_CTRL, 8'h04, "timer block");
		repeat (20) @(posedge clk_i);
		for (int a = 1; a < 13; a++) rc(4'(a), a == 7 ? 8'h5F : 8'h00, "reset value");
	endtask
	task automatic t_write;
		logic [7:0] v;
		cpu.wr(`DEW_OFS_IDX_LO, 8'hFF);
		cpu.wr(`DEW_OFS_IDX_HI, 8'h03);
		cpu.wr(`DEW_OFS_VALUE, 8'hA5);
		cpu.unlock(8'h06);
		rc(`DEW_OFS_CTRL, 8'h06, "busy");
		cpu.wr(`DEW_OFS_IDX_LO, 8'h00);
		v = 8'h02;
		for (int i = 0; i < 40 && v[1] !== 1'b0; i++) cpu.rd(`DEW_OFS_CTRL, v);
		rc(`DEW_OFS_CTRL, 8'h04, "write end");
		rc(`DEW_OFS_FLAGS, 8'h10, "done flag");
		rc(`DEW_OFS_IDX_LO, 8'hFF, "locked index");
		cpu.wr(`DEW_OFS_VALUE, 8'h00);
		cpu.wr(`DEW_OFS_CTRL, 8'h05);
		rc(`DEW_OFS_VALUE, 8'hA5, "stored byte");
	endtask
	task automatic t_irq;
		cpu.wr(`DEW_OFS_ENABLES, 8'h10);
		cpu.wr(`DEW_OFS_INTCTL, 8'hC0);
		chk("irq", 8'h01, {7'h00, irq});
		cpu.wr(`DEW_OFS_ENABLES, 8'h00);
		chk("irq masked", 8'h00, {7'h00, irq});
		cpu.wr(`DEW_OFS_ENABLES, 8'h10);
		cpu.wr(`DEW_OFS_FLAGS, 8'h10);
		chk("irq cleared", 8'h00, {7'h00, irq});
	endtask
	task automatic t_keys;
		cpu.wr(`DEW_OFS_KEY, 8'h55);
		rc(`DEW_OFS_IDX_HI, 8'h03, "index high");
		cpu.wr(`DEW_OFS_KEY, 8'hAA);
		cpu.wr(`DEW_OFS_CTRL, 8'h06);
		rc(`DEW_OFS_CTRL, 8'h04, "split key");
		cpu.wr(`DEW_OFS_CTRL, 8'h02);
		rc(`DEW_OFS_CTRL, 8'h04, "no key");
		cpu.wr(`DEW_OFS_CTRL, 8'h00);
		cpu.unlock(8'h06);
		rc(`DEW_OFS_CTRL, 8'h00, "same write");
	endtask
	task automatic t_protect;
		prot <= 1'b1;
		repeat (8) @(posedge clk_i);
		ext(1'b0, 8'h00, 1'b1);
		ext(1'b1, 8'h00, 1'b1);
		cpu.wr(`DEW_OFS_CTRL, 8'h01);
		rc(`DEW_OFS_VALUE, 8'hA5, "own read");
		prot <= 1'b0;
		repeat (8) @(posedge clk_i);
		ext(1'b0, 8'hA5, 1'b0);
	endtask
	task automatic t_abort;
		cpu.wr(`DEW_OFS_CTRL, 8'h04);
		cpu.unlock(8'h06);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(`DEW_OFS_CTRL, 8'h08, "aborted");
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge clk_i);
		t_power_up();
		t_write();
		t_irq();
		t_keys();
		t_protect();
		t_abort();
		wrap_up();
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
